// ### sld_pkg.sv
// Shared constants of the serial latched output driver.
package sld_pkg;

  // Number of shift-register stages, latches and outputs.
  localparam int SLD_WIDTH      = 10;
  // Position of the stage that feeds the serial output.
  localparam int SLD_LAST_STAGE = SLD_WIDTH - 1;
  // Depth of the crossing buffer between the link and the core.
  localparam int SLD_FIFO_DEPTH = 4;

  // System clock period and the least gap from shifting to strobe.
  localparam int SLD_SYS_CLK_NS       = 100;
  localparam int SLD_STROBE_SETUP_NS  = 100;
  localparam int SLD_STROBE_SETUP_CYC =
    (SLD_STROBE_SETUP_NS + SLD_SYS_CLK_NS - 1) / SLD_SYS_CLK_NS;

  // Values after reset.
  localparam logic SLD_STROBE_RST = 1'h0;
  localparam logic SLD_BLANK_RST  = 1'h1;
  localparam logic SLD_SINK_RST   = 1'h1;
  localparam logic SLD_LINK_RST   = 1'h1;
  localparam logic SLD_SERIAL_RST = 1'h0;

endpackage : sld_pkg

// ### sld_fifo.sv
// Dual-clock word buffer with gray-coded pointers and registered read data.
`timescale 1ns/1ps
module sld_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             wr_clk_i,
  input  wire logic             wr_rst_i,
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  input  wire logic             rd_clk_i,
  input  wire logic             rd_rst_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] FULL_XOR = {2'h3, {(PW-2){1'b0}}};

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               bin;
    logic [PW-1:0]               gray;
    logic [PW-1:0]               rg_s1;
    logic [PW-1:0]               rg_s2;
  } sld_fw_t;

  typedef struct packed {
    logic [PW-1:0]    bin;
    logic [PW-1:0]    gray;
    logic [PW-1:0]    wg_s1;
    logic [PW-1:0]    wg_s2;
    logic             valid;
    logic [WIDTH-1:0] data;
  } sld_fr_t;

  sld_fw_t wr_r;
  sld_fw_t wr_nxt;
  sld_fr_t rd_r;
  sld_fr_t rd_nxt;
  logic    full;
  logic    empty;

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  // Full is judged against a stale read pointer, so it errs on the safe side.
  assign full       = (wr_r.gray ^ wr_r.rg_s2) == FULL_XOR;
  assign empty      = rd_r.gray == rd_r.wg_s2;
  assign wr_ready_o = !full;
  assign rd_valid_o = rd_r.valid;
  assign rd_data_o  = rd_r.data;

  always_comb begin
    wr_nxt       = wr_r;
    wr_nxt.rg_s1 = rd_r.gray;
    wr_nxt.rg_s2 = wr_r.rg_s1;
    if (wr_valid_i && !full) begin
      wr_nxt.mem[wr_r.bin[AW-1:0]] = wr_data_i;
      wr_nxt.bin  = wr_r.bin + 1'b1;
      wr_nxt.gray = bin2gray(wr_nxt.bin);
    end
  end

  always_comb begin
    rd_nxt       = rd_r;
    rd_nxt.wg_s1 = wr_r.gray;
    rd_nxt.wg_s2 = rd_r.wg_s1;
    if (!rd_r.valid || rd_ready_i) begin
      rd_nxt.valid = !empty;
      if (!empty) begin
        rd_nxt.data = wr_r.mem[rd_r.bin[AW-1:0]];
        rd_nxt.bin  = rd_r.bin + 1'b1;
        rd_nxt.gray = bin2gray(rd_nxt.bin);
      end
    end
  end

  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      wr_r <= '0;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

endmodule : sld_fifo

// ### sld_driver.sv
// Serial-in, latched parallel-out driver core with blanking.
`timescale 1ns/1ps

// Summary of operation
// - Rising shift clock loads serial input into stage one.
// - Later rising edges move stages toward serial output.
// - Strobe high copies register stages into latches.
// - Latches keep tracking register while strobe stays high.
// - Blank high forces all outputs low, sinks on.
// - Blanking never alters the latch contents.
// - Blank low drives each output from its latch.
// - Register, latches and outputs are ten wide.
// - Last register stage appears on the serial output.
module sld_driver #(
  parameter int WIDTH = sld_pkg::SLD_WIDTH,
  parameter int DEPTH = sld_pkg::SLD_FIFO_DEPTH
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             shift_clk_i,
  input  wire logic             serial_data_i,
  input  wire logic             strobe_i,
  input  wire logic             output_blank_i,
  output logic                  serial_data_o,
  output logic                  link_ready_o,
  output logic      [WIDTH-1:0] drive_o,
  output logic                  sink_on_o
);

  // State that lives on the shift clock.
  typedef struct packed {
    logic             rst_s1;
    logic             rst_s2;
    logic [WIDTH-1:0] shreg;
  } sld_link_t;

  // State that lives on the system clock.
  typedef struct packed {
    logic             strb_s1;
    logic             strb_s2;
    logic             output_blank_s1;
    logic             output_blank_s2;
    logic [WIDTH-1:0] mirror;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] drive;
    logic             sink;
  } sld_core_t;

  localparam sld_link_t LINK_RST = '{
    rst_s1: sld_pkg::SLD_LINK_RST,
    rst_s2: sld_pkg::SLD_LINK_RST,
    shreg:  '0
  };

  localparam sld_core_t CORE_RST = '{
    strb_s1: sld_pkg::SLD_STROBE_RST,
    strb_s2: sld_pkg::SLD_STROBE_RST,
    output_blank_s1: sld_pkg::SLD_BLANK_RST,
    output_blank_s2: sld_pkg::SLD_BLANK_RST,
    mirror:  '0,
    latch:   '0,
    drive:   '0,
    sink:    sld_pkg::SLD_SINK_RST
  };

  sld_link_t        link_r;
  sld_link_t        link_nxt;
  sld_core_t        core_r;
  sld_core_t        core_nxt;
  logic             link_rst;
  logic             push_valid;
  logic             push_ready;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  // One step of the chain; the checks reuse it so both agree on the order.
  function automatic logic [WIDTH-1:0] shift_step(
    input logic [WIDTH-1:0] stages,
    input logic             bit_in
  );
    return {stages[WIDTH-2:0], bit_in};
  endfunction : shift_step

  // Link side.

  // The reset is released on the shift clock so the first shift after it
  // sees a clean edge; assertion is still immediate.
  assign link_rst = link_r.rst_s2;

  always_comb begin
    link_nxt        = link_r;
    link_nxt.rst_s1 = 1'b0;
    link_nxt.rst_s2 = link_r.rst_s1;
    if (!link_rst) begin
      // Stage one takes the serial input, the rest move one onward.
      link_nxt.shreg = shift_step(link_r.shreg, serial_data_i);
    end
  end

  always_ff @(posedge shift_clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_r <= LINK_RST;
    end else begin
      link_r <= link_nxt;
    end
  end

  // Every shift sends a snapshot of the whole register to the core. A
  // snapshot offered while the buffer is full is lost, so a host that
  // clocks faster than the core drains must watch the ready output.
  // Ready only moves on shift edges, so a paused host sees it stale.
  assign push_valid    = !link_rst;
  assign link_ready_o  = push_ready;
  assign serial_data_o = link_r.shreg[sld_pkg::SLD_LAST_STAGE];

  sld_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .wr_clk_i   (shift_clk_i),
    .wr_rst_i   (link_rst),
    .wr_valid_i (push_valid),
    .wr_data_i  (link_nxt.shreg),
    .wr_ready_o (push_ready),
    .rd_clk_i   (sys_clk_i),
    .rd_rst_i   (reset_i),
    .rd_valid_o (pop_valid),
    .rd_ready_i (pop_ready),
    .rd_data_o  (pop_data)
  );

  // Core side.

  // The core takes one snapshot per cycle; the link clock is slower, so the
  // buffer does not fill and its ready output stays high.
  assign pop_ready = 1'b1;

  always_comb begin
    core_nxt         = core_r;
    core_nxt.strb_s1 = strobe_i;
    core_nxt.strb_s2 = core_r.strb_s1;
    core_nxt.output_blank_s1 = output_blank_i;
    core_nxt.output_blank_s2 = core_r.output_blank_s1;
    if (pop_valid) begin
      core_nxt.mirror = pop_data;
    end
    // Transparent latch: follows the register copy while strobe is high,
    // otherwise keeps its value. Blanking has no say here.
    if (core_r.strb_s2) begin
      core_nxt.latch = core_nxt.mirror;
    end else begin
      core_nxt.latch = core_r.latch;
    end
    if (core_r.output_blank_s2) begin
      core_nxt.drive = '0;
      core_nxt.sink  = 1'b1;
    end else begin
      core_nxt.drive = core_r.latch;
      core_nxt.sink  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_r <= CORE_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign drive_o   = core_r.drive;
  assign sink_on_o = core_r.sink;

  // Checks on the link side.

  sequence s_link_run;
    !link_rst [*5] ##1 !link_rst [*5];
  endsequence

  property p_first_stage;
    @(posedge shift_clk_i) disable iff (reset_i)
    !link_rst |=> link_r.shreg[0] == $past(serial_data_i);
  endproperty
  a_first_stage: assert property (p_first_stage)
    else $error("Stage one missed the serial input.");

  property p_shift_on;
    @(posedge shift_clk_i) disable iff (reset_i)
    !link_rst |=>
      link_r.shreg[WIDTH-1:1] == $past(link_r.shreg[WIDTH-2:0]);
  endproperty
  a_shift_on: assert property (p_shift_on)
    else $error("Register did not move one stage onward.");

  property p_serial_out;
    @(posedge shift_clk_i) disable iff (reset_i)
    s_link_run |=> serial_data_o == $past(serial_data_i, WIDTH);
  endproperty
  a_serial_out: assert property (p_serial_out)
    else $error("Serial output is not the input ten shifts back.");

  property p_word_step;
    @(posedge shift_clk_i) disable iff (reset_i)
    !link_rst |=>
      link_r.shreg == shift_step($past(link_r.shreg), $past(serial_data_i));
  endproperty
  a_word_step: assert property (p_word_step)
    else $error("Register is not the previous one shifted by one bit.");

  property p_sync_hold;
    @(posedge shift_clk_i) disable iff (reset_i)
    link_rst |=> link_r.shreg == $past(link_r.shreg);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("Register shifted before the link reset was released.");

  property p_sync_release;
    @(posedge shift_clk_i) disable iff (reset_i)
    !link_r.rst_s1 |=> !link_rst;
  endproperty
  a_sync_release: assert property (p_sync_release)
    else $error("Link reset did not release after two shift edges.");

  // Checks on the core side.

  sequence s_strobe_on;
    core_r.strb_s2 ##0 pop_valid;
  endsequence

  property p_strobe_copy;
    @(posedge sys_clk_i) disable iff (reset_i)
    s_strobe_on |=> core_r.latch == $past(pop_data);
  endproperty
  a_strobe_copy: assert property (p_strobe_copy)
    else $error("Strobe did not copy the register into the latches.");

  property p_strobe_track;
    @(posedge sys_clk_i) disable iff (reset_i)
    core_r.strb_s2 [*2] |=> core_r.latch == core_r.mirror;
  endproperty
  a_strobe_track: assert property (p_strobe_track)
    else $error("Latches stopped tracking while strobe was high.");

  property p_strobe_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
    !core_r.strb_s2 |=> $stable(core_r.latch);
  endproperty
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("Latches changed while strobe was low.");

  sequence s_outputs_off;
    drive_o == '0 && sink_on_o;
  endsequence

  property p_blank_low;
    @(posedge sys_clk_i) disable iff (reset_i)
    core_r.output_blank_s2 |=> s_outputs_off;
  endproperty
  a_blank_low: assert property (p_blank_low)
    else $error("Outputs not forced low while blanked.");

  property p_blank_keeps;
    @(posedge sys_clk_i) disable iff (reset_i)
    core_r.output_blank_s2 && core_r.strb_s2 |=> core_r.latch == core_r.mirror;
  endproperty
  a_blank_keeps: assert property (p_blank_keeps)
    else $error("Blanking disturbed the latches.");

  property p_unblank_drive;
    @(posedge sys_clk_i) disable iff (reset_i)
    !core_r.output_blank_s2 ##1 !core_r.output_blank_s2 |->
      drive_o == $past(core_r.latch) && !sink_on_o;
  endproperty
  a_unblank_drive: assert property (p_unblank_drive)
    else $error("Outputs do not follow the latches when unblanked.");

  // Pin edges pass two sync flops and one register: three edges in all.
  property p_blank_pin;
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(output_blank_i) |-> ##3 s_outputs_off;
  endproperty
  a_blank_pin: assert property (p_blank_pin)
    else $error("Blanking pin did not turn the outputs off in time.");

  property p_unblank_pin;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(output_blank_i) |-> ##3 !sink_on_o;
  endproperty
  a_unblank_pin: assert property (p_unblank_pin)
    else $error("Sinks stayed on after the blanking pin fell.");

  property p_drive_sink;
    @(posedge sys_clk_i) disable iff (reset_i)
    sink_on_o |-> drive_o == '0;
  endproperty
  a_drive_sink: assert property (p_drive_sink)
    else $error("An output drives high while the sinks are on.");

  property p_strobe_pin;
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(strobe_i) |-> ##3 core_r.latch == core_r.mirror;
  endproperty
  a_strobe_pin: assert property (p_strobe_pin)
    else $error("Strobe pin did not open the latches in time.");

  property p_strobe_pin_low;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(strobe_i) |-> ##3 $stable(core_r.latch);
  endproperty
  a_strobe_pin_low: assert property (p_strobe_pin_low)
    else $error("Latches moved after the strobe pin fell.");

  property p_mirror_load;
    @(posedge sys_clk_i) disable iff (reset_i)
    pop_valid |=> core_r.mirror == $past(pop_data);
  endproperty
  a_mirror_load: assert property (p_mirror_load)
    else $error("Register copy missed a snapshot from the buffer.");

  property p_mirror_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
    !pop_valid |=> $stable(core_r.mirror);
  endproperty
  a_mirror_hold: assert property (p_mirror_hold)
    else $error("Register copy changed with no snapshot.");

  property p_unblank_sink;
    @(posedge sys_clk_i) disable iff (reset_i)
    !core_r.output_blank_s2 |=> !sink_on_o;
  endproperty
  a_unblank_sink: assert property (p_unblank_sink)
    else $error("Sinks on while not blanked.");

  property p_blank_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
    core_r.output_blank_s2 && !core_r.strb_s2 |=> $stable(core_r.latch);
  endproperty
  a_blank_hold: assert property (p_blank_hold)
    else $error("Latches changed during blanking with strobe low.");

endmodule : sld_driver

// ### sld_host_model.sv
// Host model that clocks words into the driver's serial link.
`timescale 1ns/1ps
module sld_host_model (
  input  wire logic link_ready_i,
  output logic      shift_clk_o,
  output logic      serial_data_o
);
  localparam int HALF_NS = 24;
  // Idle time before each rise. The link side learns of free buffer space
  // only on its own edges, so the host paces itself instead of waiting.
  localparam int GAP_NS  = 400;

  // The link clock stands still low between frames.
  initial begin
    shift_clk_o   = 1'b0;
    serial_data_o = 1'b0;
  end

  // Data changes well ahead of the rise that takes it.
  task automatic pulse(input logic bit_v);
    serial_data_o = bit_v;
    #GAP_NS;
    #HALF_NS shift_clk_o = 1'b1;
    #HALF_NS shift_clk_o = 1'b0;
  endtask : pulse

  // Two pulses load the link reset synchronizer before real bits.
  task automatic wake();
    pulse(1'b1);
    pulse(1'b0);
  endtask : wake

  // Highest bit goes first; ok drops if any shift met a full buffer.
  task automatic send_word(input logic [sld_pkg::SLD_WIDTH-1:0] w,
                           output logic ok);
    ok = 1'b1;
    for (int i = sld_pkg::SLD_WIDTH - 1; i >= 0; i--) begin
      if (link_ready_i !== 1'b1) ok = 1'b0;
      pulse(w[i]);
    end
    // A released line must not look like a held bit.
    serial_data_o = ~w[0];
  endtask : send_word
endmodule : sld_host_model

// ### tb_serial_latched_output_driver.sv
// Self-checking bench for the serial latched output driver.
`timescale 1ns/1ps
module tb_serial_latched_output_driver;
  localparam int W = sld_pkg::SLD_WIDTH;
  logic         sys_clk_i;
  logic         reset_i;
  logic         strobe_i;
  logic         output_blank_i;
  logic         shift_clk;
  logic         serial_in;
  logic         serial_data_o;
  logic         link_ready_o;
  logic [W-1:0] drive_o;
  logic         sink_on_o;
  logic         ok;
  int           mismatches;
  int           checks_done;

  sld_driver #(.WIDTH(W), .DEPTH(sld_pkg::SLD_FIFO_DEPTH)) DUT (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .shift_clk_i    (shift_clk),
    .serial_data_i  (serial_in),
    .strobe_i       (strobe_i),
    .output_blank_i (output_blank_i),
    .serial_data_o  (serial_data_o),
    .link_ready_o   (link_ready_o),
    .drive_o        (drive_o),
    .sink_on_o      (sink_on_o)
  );

  sld_host_model HOST (
    .link_ready_i  (link_ready_o),
    .shift_clk_o   (shift_clk),
    .serial_data_o (serial_in)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [W-1:0] seen,
                       input logic [W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cycles

  task automatic pins(input logic s, input logic b);
    @(posedge sys_clk_i);
    strobe_i       <= s;
    output_blank_i <= b;
  endtask : pins

  // The wait lets each snapshot cross before strobe may rise.
  task automatic send(input logic [W-1:0] w);
    HOST.send_word(w, ok);
    check("link_ready", ok, 1'b1);
    cycles(10);
  endtask : send

  task automatic t_reset();
    check("drive", drive_o, '0);
    check("sink", sink_on_o, 1'b1);
    check("serial_out", serial_data_o, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Complementary words set every output both high and low.
  task automatic t_load();
    logic [W-1:0] words [2] = '{10'h2A5, 10'h15A};
    logic [W-1:0] prev = '0;
    pins(1'b0, 1'b0);
    foreach (words[i]) begin
      send(words[i]);
      check("held", drive_o, prev);
      pins(1'b1, 1'b0);
      cycles(8);
      check("latched", drive_o, words[i]);
      check("serial_out", serial_data_o, words[i][W-1]);
      check("sink_off", sink_on_o, 1'b0);
      pins(1'b0, 1'b0);
      cycles(4);
      prev = words[i];
    end
    $display("test load done");
  endtask : t_load

  task automatic t_track();
    pins(1'b1, 1'b0);
    send(10'h0FF);
    check("tracked", drive_o, 10'h0FF);
    pins(1'b0, 1'b0);
    cycles(4);
    $display("test track done");
  endtask : t_track

  task automatic t_blank();
    pins(1'b0, 1'b1);
    cycles(6);
    check("blanked", drive_o, '0);
    check("sink_on", sink_on_o, 1'b1);
    pins(1'b0, 1'b0);
    cycles(6);
    check("kept", drive_o, 10'h0FF);
    pins(1'b1, 1'b1);
    send(10'h3C3);
    check("bypass", drive_o, '0);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    cycles(6);
    check("bypass_word", drive_o, 10'h3C3);
    $display("test blank done");
  endtask : t_blank

  initial begin
    reset_i        = 1'b1;
    strobe_i       = 1'b0;
    output_blank_i = 1'b1;
    mismatches     = 0;
    checks_done    = 0;
    ok             = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    cycles(2);
    t_reset();
    HOST.wake();
    t_load();
    t_track();
    t_blank();
    complete_run();
  end

  // A hang is cut short and counted against the run.
  initial begin
    #2000000;
    mismatches++;
    complete_run();
  end
endmodule : tb_serial_latched_output_driver
